// file: logic/sps_regs.svh
// Register map, field positions, reset values and counts of the status pin selector
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH

// Register indices; byte address is four times the index
`define SPS_IDX_SEL_ABL 10'h017
`define SPS_IDX_LOCK_CFG 10'h018
`define SPS_IDX_REFERENCE_MONITOR_PIN_OVR 10'h01D
`define SPS_IDX_IRQ_STAT 10'h020
`define SPS_IDX_IRQ_MASK 10'h021
`define SPS_IDX_LIVE 10'h022

// Field positions
`define SPS_SEL_MSB 7
`define SPS_SEL_LSB 2
`define SPS_ABL_MSB 1
`define SPS_ABL_LSB 0
`define SPS_DCOFS_BIT 7
`define SPS_LCNT_MSB 6
`define SPS_LCNT_LSB 5
`define SPS_OVR_BIT 7

// Reset values
`define SPS_RST_SEL 6'h00
`define SPS_RST_ABL 2'h0
`define SPS_RST_DCOFS 1'b0
`define SPS_RST_LCNT 2'h0
`define SPS_RST_OVR 1'b0
`define SPS_RST_MASK 3'h0

// Phase detector cycles needed for lock, per counter code
`define SPS_LOCK_CNT_0 8'h05
`define SPS_LOCK_CNT_1 8'h10
`define SPS_LOCK_CNT_2 8'h40
`define SPS_LOCK_CNT_3 8'hFF

// Bus responses
`define SPS_RESP_OKAY 2'h0
`define SPS_RESP_SLVERR 2'h2

`endif

// file: logic/sps_pkg.sv
// Types shared by the status pin selector
package sps_pkg;

  typedef logic [5:0] sps_sel_t;

  // Read channel states, one-hot
  typedef enum logic [1:0] {
    SPS_RD_IDLE = 2'b01,
    SPS_RD_RESP = 2'b10
  } sps_rd_state_t;

  // Interrupt status layout: lock gained, lock lost, holdover entered
  typedef logic [2:0] sps_irq_t;

endpackage : sps_pkg

// file: logic/sps_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module sps_sync #(
  parameter int W = 1
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // Output follows only when stages two and three agree; stage one feeds stage two alone
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      o_sync <= '0;
    end else begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      o_sync <= ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & o_sync);
    end
  end
endmodule : sps_sync

// file: logic/sps_lock_cnt.sv
// Digital lock flag: consecutive in-window phase detector cycles
`timescale 1ns/1ps
module sps_lock_cnt (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic i_in_win,
  input wire logic i_loss,
  input wire logic [7:0] i_target,
  output logic o_lock
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_inc;
  logic hit;

  // Saturating count so a long lock run never wraps
  assign cnt_inc = (cnt_r == 8'hFF) ? cnt_r : cnt_r + 8'h01;
  assign hit = i_tick && i_in_win && (cnt_inc >= i_target);

  // A cycle outside the window restarts the run; only loss clears the flag
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= 8'h00;
      o_lock <= 1'b0;
    end else begin
      if (i_tick) begin
        cnt_r <= i_in_win ? cnt_inc : 8'h00;
      end
      if (i_loss) begin
        o_lock <= 1'b0;
      end else if (hit) begin
        o_lock <= 1'b1;
      end
    end
  end

  property p_lock_sets;
    @(posedge i_clk_sys) disable iff (!i_rst_n) hit && !i_loss |=> o_lock;
  endproperty
  a_lock_sets: assert property (p_lock_sets) else $error("lock flag missed its count");
  // Compare the saturated count, so a run held at the top value cannot wrap to zero here
  property p_lock_early;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(o_lock) |-> $past(i_tick) && $past(i_in_win) && ($past(cnt_inc) >= $past(i_target));
  endproperty
  a_lock_early: assert property (p_lock_early) else $error("lock flag rose before count reached");
  property p_lock_holds;
    @(posedge i_clk_sys) disable iff (!i_rst_n) o_lock && !i_loss |=> o_lock;
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("lock flag dropped without loss");
  property p_lock_clears;
    @(posedge i_clk_sys) disable iff (!i_rst_n) i_loss |=> !o_lock;
  endproperty
  a_lock_clears: assert property (p_lock_clears) else $error("lock flag survived loss");
endmodule : sps_lock_cnt

// file: logic/sps_top.sv
// Status pin selector with lock counter, loop settings and AXI4-Lite registers
`timescale 1ns/1ps
`include "sps_regs.svh"

// Notes on behaviour
// - Low select half, unlisted code: status pin held at ground.
// - Top select bit set: status pin offers the reference monitor list.
// - First reference clock option; differential reference in differential mode.
// - Second reference clock option; unavailable (ground) in differential mode.
// - Chosen loop reference clock; differential reference in differential mode.
// - Unchosen reference clock; unavailable in differential mode.
// - Chosen reference monitor status, active high; differential status in that mode.
// - Unchosen reference monitor status, active high; unavailable in differential mode.
// - Separate first and second reference status, plus their AND.
// - Lock AND chosen status AND oscillator status; oscillator status alone too.
// - Reference choice level: low for first, high for second reference.
// - Lock flag, holdover and lock pin comparator levels, active high.
// - Inverted group of level options; reference choice low for second reference.
// - Two-bit pulse width code: 2.9 default, 1.3, 6.0, 2.9 ns.
// - Dc offset enable for single-ended reference input, reset disabled.
// - Lock flag asserts after set count of in-window cycles, default five.
// - Lock flag stays set until loss-of-lock threshold is exceeded.
module sps_top (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [11:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_n_div,
  input wire logic i_r_div,
  input wire logic i_a_div,
  input wire logic i_prescaler,
  input wire logic i_pfd_up,
  input wire logic i_pfd_dn,
  input wire logic i_first_reference_input_clk,
  input wire logic i_second_reference_input_clk,
  input wire logic i_diff_clk,
  input wire logic i_first_reference_input_ok,
  input wire logic i_second_reference_input_ok,
  input wire logic i_diff_ok,
  input wire logic i_vco_ok,
  input wire logic i_ref_sel,
  input wire logic i_diff_mode,
  input wire logic i_holdover,
  input wire logic i_ld_comp,
  input wire logic i_in_win,
  input wire logic i_lock_loss,
  input wire logic i_pfd_clk,
  output logic o_status_pin,
  output logic [1:0] o_abl_code,
  output logic o_dc_offset_en,
  output logic o_lock_flag,
  output logic o_irq
);
  localparam int SW = 20;

  // Reset release through two flops
  logic rst_q1_r;
  logic rst_n;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_q1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_n <= rst_q1_r;
    end
  end

  // Pin inputs, all asynchronous to the system clock
  logic [SW-1:0] sync_q;
  logic n_s, r_s, a_s, pre_s, up_s, dn_s, first_reference_input_s, second_reference_input_s, diffc_s, ok1_s, ok2_s;
  logic okd_s, vco_s, rsel_s, diff_s, hold_s, ldc_s, win_s, loss_s, pfdc_s;
  sps_sync #(.W(SW)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_async({i_pfd_clk, i_lock_loss, i_in_win, i_ld_comp, i_holdover, i_diff_mode, i_ref_sel, i_vco_ok,
              i_diff_ok, i_second_reference_input_ok, i_first_reference_input_ok, i_diff_clk, i_second_reference_input_clk, i_first_reference_input_clk, i_pfd_dn, i_pfd_up,
              i_prescaler, i_a_div, i_r_div, i_n_div}),
    .o_sync(sync_q)
  );
  assign {pfdc_s, loss_s, win_s, ldc_s, hold_s, diff_s, rsel_s, vco_s, okd_s, ok2_s, ok1_s, diffc_s,
          second_reference_input_s, first_reference_input_s, dn_s, up_s, pre_s, a_s, r_s, n_s} = sync_q;

  // Control registers
  sps_pkg::sps_sel_t sel_r;
  logic [1:0] lcnt_r;
  logic ovr_r;
  sps_pkg::sps_irq_t irq_stat_r;
  sps_pkg::sps_irq_t irq_mask_r;

  // Write channel: address and data taken in either order, one write at a time
  logic aw_ok_r;
  logic w_ok_r;
  logic [11:0] awaddr_r;
  logic [7:0] wbyte_r;
  logic wstrb0_r;
  logic wr_go;
  logic [9:0] wr_idx;
  logic wr_map;
  logic wr_sel;
  logic wr_lck;
  logic wr_ovr;
  logic wr_clr;
  logic wr_msk;

  assign wr_go = aw_ok_r && w_ok_r && !o_bvalid;
  assign wr_idx = awaddr_r[11:2];
  assign wr_sel = wr_go && wstrb0_r && (wr_idx == `SPS_IDX_SEL_ABL);
  assign wr_lck = wr_go && wstrb0_r && (wr_idx == `SPS_IDX_LOCK_CFG);
  assign wr_ovr = wr_go && wstrb0_r && (wr_idx == `SPS_IDX_REFERENCE_MONITOR_PIN_OVR);
  assign wr_clr = wr_go && wstrb0_r && (wr_idx == `SPS_IDX_IRQ_STAT);
  assign wr_msk = wr_go && wstrb0_r && (wr_idx == `SPS_IDX_IRQ_MASK);
  assign wr_map = (wr_idx == `SPS_IDX_SEL_ABL) || (wr_idx == `SPS_IDX_LOCK_CFG) ||
                  (wr_idx == `SPS_IDX_REFERENCE_MONITOR_PIN_OVR) || (wr_idx == `SPS_IDX_IRQ_STAT) ||
                  (wr_idx == `SPS_IDX_IRQ_MASK) || (wr_idx == `SPS_IDX_LIVE);

  // Readies re-arm only once the response is taken, so a second write cannot overtake
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      awaddr_r <= 12'h000;
      wbyte_r <= 8'h00;
      wstrb0_r <= 1'b0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= `SPS_RESP_OKAY;
    end else begin
      if (!aw_ok_r && !o_bvalid && !o_awready) o_awready <= 1'b1;
      if (!w_ok_r && !o_bvalid && !o_wready) o_wready <= 1'b1;
      if (i_awvalid && o_awready) begin
        aw_ok_r <= 1'b1;
        awaddr_r <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_ok_r <= 1'b1;
        wbyte_r <= i_wdata[7:0];
        wstrb0_r <= i_wstrb[0];
        o_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= wr_map ? `SPS_RESP_OKAY : `SPS_RESP_SLVERR;
      end
      if (o_bvalid && i_bready) o_bvalid <= 1'b0;
    end
  end

  // Configuration fields; the whole select field changes in one edge
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_r <= `SPS_RST_SEL;
      o_abl_code <= `SPS_RST_ABL;
      o_dc_offset_en <= `SPS_RST_DCOFS;
      lcnt_r <= `SPS_RST_LCNT;
      ovr_r <= `SPS_RST_OVR;
      irq_mask_r <= `SPS_RST_MASK;
    end else begin
      if (wr_sel) begin
        sel_r <= wbyte_r[`SPS_SEL_MSB:`SPS_SEL_LSB];
        o_abl_code <= wbyte_r[`SPS_ABL_MSB:`SPS_ABL_LSB];
      end
      if (wr_lck) begin
        o_dc_offset_en <= wbyte_r[`SPS_DCOFS_BIT];
        lcnt_r <= wbyte_r[`SPS_LCNT_MSB:`SPS_LCNT_LSB];
      end
      if (wr_ovr) ovr_r <= wbyte_r[`SPS_OVR_BIT];
      if (wr_msk) irq_mask_r <= wbyte_r[2:0];
    end
  end

  // Lock flag counter, phase detector cycle marked by a rising comparison clock
  logic pfdc_d_r;
  logic pfd_tick;
  logic [7:0] lock_target;
  logic lock_w;
  assign pfd_tick = pfdc_s && !pfdc_d_r;
  assign lock_target = (lcnt_r == 2'h0) ? `SPS_LOCK_CNT_0 :
                       (lcnt_r == 2'h1) ? `SPS_LOCK_CNT_1 :
                       (lcnt_r == 2'h2) ? `SPS_LOCK_CNT_2 : `SPS_LOCK_CNT_3;
  sps_lock_cnt u_lock (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_tick(pfd_tick),
    .i_in_win(win_s),
    .i_loss(loss_s),
    .i_target(lock_target),
    .o_lock(lock_w)
  );

  // Signals derived from the reference choice; differential mode overrides both refs in all but both_ok
  logic sel_clk, unsel_clk, first_reference_input_or_diff, second_reference_input_av, sel_ok, unsel_ok, both_ok, lock_all;
  assign first_reference_input_or_diff = diff_s ? diffc_s : first_reference_input_s;
  assign second_reference_input_av = !diff_s && second_reference_input_s;
  assign sel_clk = diff_s ? diffc_s : (rsel_s ? second_reference_input_s : first_reference_input_s);
  assign unsel_clk = !diff_s && (rsel_s ? first_reference_input_s : second_reference_input_s);
  assign sel_ok = diff_s ? okd_s : (rsel_s ? ok2_s : ok1_s);
  assign unsel_ok = !diff_s && (rsel_s ? ok1_s : ok2_s);
  assign both_ok = ok1_s && ok2_s;
  assign lock_all = lock_w && sel_ok && vco_s;

  // Level options shared by the true and inverted groups, codes 5 to 15 then 21 to 31
  logic [10:0] lvl;
  logic [10:0] lvl_n;
  assign lvl = {ldc_s, hold_s, lock_w, rsel_s, vco_s, lock_all, both_ok, ok2_s, ok1_s, unsel_ok, sel_ok};
  // In differential mode the unused-reference status reads ground in both groups
  assign lvl_n = {~lvl[10:2], ~lvl[1] && !diff_s, ~lvl[0]};

  // Selection tables; the supply option reads as a constant high level
  logic [6:0] base_opts;
  logic [31:0] mon_opts;
  logic base_hit;
  logic status_nxt;
  assign base_opts = {dn_s, up_s, pre_s, a_s, r_s, n_s, 1'b0};
  assign mon_opts = {lvl_n, unsel_clk, sel_clk, second_reference_input_av, first_reference_input_or_diff, 1'b1, lvl,
                     unsel_clk, sel_clk, second_reference_input_av, first_reference_input_or_diff, 1'b0};
  assign base_hit = (sel_r[4:3] == 2'h0) && (sel_r[2:0] != 3'h7);
  assign status_nxt = sel_r[5] ? mon_opts[sel_r[4:0]] :
                      (base_hit && base_opts[sel_r[2:0]]);

  // Interrupt events: lock gained, lock lost, holdover entered; a new event beats the clear
  logic lock_d_r;
  logic hold_d_r;
  sps_pkg::sps_irq_t irq_ev;
  sps_pkg::sps_irq_t irq_nxt;
  assign irq_ev = {hold_s && !hold_d_r, !lock_w && lock_d_r, lock_w && !lock_d_r};
  assign irq_nxt = (irq_stat_r & ~(wr_clr ? wbyte_r[2:0] : 3'h0)) | irq_ev;

  // Output flops and edge history
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pfdc_d_r <= 1'b0;
      lock_d_r <= 1'b0;
      hold_d_r <= 1'b0;
      irq_stat_r <= 3'h0;
      o_status_pin <= 1'b0;
      o_lock_flag <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      pfdc_d_r <= pfdc_s;
      lock_d_r <= lock_w;
      hold_d_r <= hold_s;
      irq_stat_r <= irq_nxt;
      o_status_pin <= status_nxt;
      o_lock_flag <= lock_w;
      o_irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Read channel: one read at a time, answer one cycle after the address is taken
  sps_pkg::sps_rd_state_t rd_st_r;
  logic [9:0] rd_idx;
  logic [7:0] rd_byte;
  logic rd_map;
  assign rd_idx = i_araddr[11:2];
  assign rd_map = (rd_idx == `SPS_IDX_SEL_ABL) || (rd_idx == `SPS_IDX_LOCK_CFG) ||
                  (rd_idx == `SPS_IDX_REFERENCE_MONITOR_PIN_OVR) || (rd_idx == `SPS_IDX_IRQ_STAT) ||
                  (rd_idx == `SPS_IDX_IRQ_MASK) || (rd_idx == `SPS_IDX_LIVE);
  assign rd_byte = (rd_idx == `SPS_IDX_SEL_ABL) ? {sel_r, o_abl_code} :
                   (rd_idx == `SPS_IDX_LOCK_CFG) ? {o_dc_offset_en, lcnt_r, 5'h00} :
                   (rd_idx == `SPS_IDX_REFERENCE_MONITOR_PIN_OVR) ? {ovr_r, 7'h00} :
                   (rd_idx == `SPS_IDX_IRQ_STAT) ? {5'h00, irq_stat_r} :
                   (rd_idx == `SPS_IDX_IRQ_MASK) ? {5'h00, irq_mask_r} :
                   (rd_idx == `SPS_IDX_LIVE) ? {5'h00, o_status_pin, hold_s, lock_w} : 8'h00;

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_st_r <= sps_pkg::SPS_RD_IDLE;
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= `SPS_RESP_OKAY;
    end else begin
      case (rd_st_r)
        sps_pkg::SPS_RD_IDLE: begin
          o_arready <= 1'b1;
          if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= {24'h000000, rd_byte};
            o_rresp <= rd_map ? `SPS_RESP_OKAY : `SPS_RESP_SLVERR;
            rd_st_r <= sps_pkg::SPS_RD_RESP;
          end
        end
        sps_pkg::SPS_RD_RESP: begin
          if (i_rready) begin
            o_rvalid <= 1'b0;
            rd_st_r <= sps_pkg::SPS_RD_IDLE;
          end
        end
        default: begin
          rd_st_r <= sps_pkg::SPS_RD_IDLE;
        end
      endcase
    end
  end

  // Checks on the pin selection and register effects
  sequence s_sel_write;
    wr_sel;
  endsequence
  property p_gnd_unlisted;
    @(posedge i_clk_sys) disable iff (!rst_n)
      !sel_r[5] && (sel_r[4:3] != 2'h0 || sel_r[2:0] == 3'h7 || sel_r[2:0] == 3'h0) |=> !o_status_pin;
  endproperty
  a_gnd_unlisted: assert property (p_gnd_unlisted) else $error("unlisted select not ground");
  property p_first_reference_input_opt;
    @(posedge i_clk_sys) disable iff (!rst_n)
      sel_r == 6'h21 |=> o_status_pin == $past(diff_s ? diffc_s : first_reference_input_s);
  endproperty
  a_first_reference_input_opt: assert property (p_first_reference_input_opt) else $error("first reference option wrong");
  property p_second_reference_input_diff;
    @(posedge i_clk_sys) disable iff (!rst_n) (sel_r == 6'h22 || sel_r == 6'h24) && diff_s |=> !o_status_pin;
  endproperty
  a_second_reference_input_diff: assert property (p_second_reference_input_diff) else $error("unavailable option not ground");
  property p_lock_and;
    @(posedge i_clk_sys) disable iff (!rst_n)
      sel_r == 6'h2A |=> o_status_pin == ($past(lock_w) && $past(sel_ok) && $past(vco_s));
  endproperty
  a_lock_and: assert property (p_lock_and) else $error("lock AND option wrong");
  property p_choice_hi;
    @(posedge i_clk_sys) disable iff (!rst_n) sel_r == 6'h2C |=> o_status_pin == $past(rsel_s);
  endproperty
  a_choice_hi: assert property (p_choice_hi) else $error("reference choice level wrong");
  property p_choice_lo;
    @(posedge i_clk_sys) disable iff (!rst_n) sel_r == 6'h3C |=> o_status_pin == !$past(rsel_s);
  endproperty
  a_choice_lo: assert property (p_choice_lo) else $error("inverted reference choice wrong");
  property p_abl_write;
    @(posedge i_clk_sys) disable iff (!rst_n) s_sel_write |=> o_abl_code == $past(wbyte_r[1:0]);
  endproperty
  a_abl_write: assert property (p_abl_write) else $error("pulse width code not stored");
  property p_dcofs_write;
    @(posedge i_clk_sys) disable iff (!rst_n) wr_lck |=> o_dc_offset_en == $past(wbyte_r[7]);
  endproperty
  a_dcofs_write: assert property (p_dcofs_write) else $error("dc offset enable not stored");
  property p_sel_only_on_write;
    @(posedge i_clk_sys) disable iff (!rst_n) $changed(sel_r) |-> $past(wr_sel) && o_bvalid;
  endproperty
  a_sel_only_on_write: assert property (p_sel_only_on_write) else $error("select moved without write");
endmodule : sps_top

// file: tb/sps_top_test.sv
// Self-checking testbench of the status pin selector
`timescale 1ns/1ps
`include "sps_regs.svh"
module sps_top_test;
  // Pin bundle masks: n_div at bit 16 down to ld_comp at bit 0
  localparam logic [16:0] b_n = 17'h10000, b_r = 17'h08000, b_a = 17'h04000, b_ps = 17'h02000;
  localparam logic [16:0] b_up = 17'h01000, b_dn = 17'h00800, b_c1 = 17'h00400, b_c2 = 17'h00200;
  localparam logic [16:0] b_cd = 17'h00100, b_k1 = 17'h00080, b_k2 = 17'h00040, b_kd = 17'h00020;
  localparam logic [16:0] b_kv = 17'h00010, b_sel = 17'h00008, b_dif = 17'h00004, b_ho = 17'h00002;
  localparam logic [16:0] b_ld = 17'h00001, b_all = 17'h1FFFF;
  localparam logic [11:0] a_sel = {`SPS_IDX_SEL_ABL, 2'b00};
  localparam logic [11:0] a_lck = {`SPS_IDX_LOCK_CFG, 2'b00};
  localparam logic [11:0] a_ist = {`SPS_IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] a_imk = {`SPS_IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] a_ovr = {`SPS_IDX_REFERENCE_MONITOR_PIN_OVR, 2'b00};
  localparam logic [11:0] a_liv = {`SPS_IDX_LIVE, 2'b00};
  typedef struct packed {logic [5:0] sel; logic [16:0] pins; logic exp;} sps_row_t;
  // Select code, pin levels and the level expected at the status pin
  localparam sps_row_t rows [0:47] = '{
    '{6'h00, b_all, 1'b0}, '{6'h01, b_n, 1'b1}, '{6'h01, b_all ^ b_n, 1'b0}, '{6'h02, b_r, 1'b1},
    '{6'h03, b_a, 1'b1}, '{6'h04, b_ps, 1'b1}, '{6'h05, b_up, 1'b1}, '{6'h06, b_dn, 1'b1},
    '{6'h07, b_all, 1'b0}, '{6'h1F, b_all, 1'b0}, '{6'h20, b_all, 1'b0}, '{6'h21, b_c1, 1'b1},
    '{6'h21, b_dif | b_cd, 1'b1}, '{6'h21, b_dif | b_c1, 1'b0}, '{6'h22, b_c2, 1'b1},
    '{6'h22, b_dif | b_c2, 1'b0}, '{6'h23, b_sel | b_c2, 1'b1}, '{6'h23, b_sel | b_c1, 1'b0},
    '{6'h23, b_dif | b_cd, 1'b1}, '{6'h24, b_c1 | b_sel, 1'b1}, '{6'h24, b_c1, 1'b0},
    '{6'h24, b_all, 1'b0}, '{6'h25, b_k2 | b_sel, 1'b1}, '{6'h25, b_dif | b_kd, 1'b1},
    '{6'h26, b_k1 | b_sel, 1'b1}, '{6'h26, b_all, 1'b0}, '{6'h27, b_k1, 1'b1}, '{6'h28, b_k2, 1'b1},
    '{6'h29, b_k1, 1'b0}, '{6'h29, b_k1 | b_k2, 1'b1}, '{6'h2B, b_kv, 1'b1}, '{6'h2C, b_sel, 1'b1},
    '{6'h2C, 17'h0, 1'b0}, '{6'h2D, b_all, 1'b0}, '{6'h2E, b_ho, 1'b1}, '{6'h2F, b_ld, 1'b1},
    '{6'h30, 17'h0, 1'b1}, '{6'h31, b_c1, 1'b1}, '{6'h34, b_c2, 1'b1}, '{6'h35, b_k1, 1'b0},
    '{6'h35, 17'h0, 1'b1}, '{6'h36, b_all, 1'b0}, '{6'h3B, 17'h0, 1'b1}, '{6'h3C, 17'h0, 1'b1},
    '{6'h3C, b_sel, 1'b0}, '{6'h3D, 17'h0, 1'b1}, '{6'h3E, b_ho, 1'b0}, '{6'h3F, 17'h0, 1'b1}};
  logic i_clk_sys, i_resetn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic i_in_win, i_lock_loss, i_pfd_clk;
  logic [11:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata;
  logic [3:0] i_wstrb;
  logic [16:0] pins;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_status_pin, o_dc_offset_en, o_lock_flag, o_irq;
  logic [1:0] o_bresp, o_rresp, o_abl_code;
  logic [31:0] o_rdata;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;

  sps_top sps_top_inst (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .i_n_div(pins[16]), .i_r_div(pins[15]), .i_a_div(pins[14]), .i_prescaler(pins[13]), .i_pfd_up(pins[12]),
    .i_pfd_dn(pins[11]), .i_first_reference_input_clk(pins[10]), .i_second_reference_input_clk(pins[9]), .i_diff_clk(pins[8]),
    .i_first_reference_input_ok(pins[7]), .i_second_reference_input_ok(pins[6]), .i_diff_ok(pins[5]), .i_vco_ok(pins[4]), .i_ref_sel(pins[3]),
    .i_diff_mode(pins[2]), .i_holdover(pins[1]), .i_ld_comp(pins[0]), .i_in_win(i_in_win),
    .i_lock_loss(i_lock_loss), .i_pfd_clk(i_pfd_clk), .o_status_pin(o_status_pin), .o_abl_code(o_abl_code),
    .o_dc_offset_en(o_dc_offset_en), .o_lock_flag(o_lock_flag), .o_irq(o_irq));

  // Free-running system clock, 100 ns period
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  // Hang guard: the whole sequence needs well under 5000 cycles
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      complete_run();
    end
  end

  task complete_run;
    if (errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t %s got %h expected %h", $time, m, g, e);
    end
  endtask : chk

  // Address and data offered together; each released once taken
  task axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge i_clk_sys);
    i_awaddr <= a;
    i_awvalid <= 1'b1;
    i_wdata <= d;
    i_wstrb <= s;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (aw || w) begin
      @(posedge i_clk_sys);
      if (aw && o_awready) begin
        aw = 1'b0;
        i_awvalid <= 1'b0;
      end
      if (w && o_wready) begin
        w = 1'b0;
        i_wvalid <= 1'b0;
      end
    end
    do @(posedge i_clk_sys); while (!o_bvalid);
    i_bready <= 1'b0;
    chk(32'(o_bresp), 32'(r), "write response");
  endtask : axi_write

  task rd_chk(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
    @(posedge i_clk_sys);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do @(posedge i_clk_sys); while (!o_arready);
    i_arvalid <= 1'b0;
    do @(posedge i_clk_sys); while (!o_rvalid);
    i_rready <= 1'b0;
    chk(o_rdata & m, d, "read data");
    chk(32'(o_rresp), 32'(r), "read response");
  endtask : rd_chk

  task run_row(input logic [5:0] s, input logic [16:0] p, input logic e);
    @(posedge i_clk_sys);
    pins <= p;
    axi_write(a_sel, {24'h0, s, 2'h0}, 4'hF, `SPS_RESP_OKAY);
    repeat (8) @(posedge i_clk_sys);
    chk(32'(o_status_pin), 32'(e), "status pin");
  endtask : run_row

  // Each edge is held long enough to pass the input synchroniser
  task pfd_edges(input int n);
    repeat (n) begin
      @(posedge i_clk_sys);
      i_pfd_clk <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      i_pfd_clk <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
    end
    repeat (8) @(posedge i_clk_sys);
  endtask : pfd_edges

  initial begin
    {i_resetn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_in_win, i_lock_loss, i_pfd_clk} = '0;
    {i_awaddr, i_araddr, i_wdata, i_wstrb, pins} = '0;
    repeat (8) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    chk(32'({o_status_pin, o_abl_code, o_dc_offset_en, o_lock_flag, o_irq}), 32'h0, "reset outputs");
    rd_chk(a_lck, 32'h0, 32'hFFFFFFFF, `SPS_RESP_OKAY);
    // Override bit is storage only; software clears it before any select write
    axi_write(a_ovr, 32'h80, 4'hF, `SPS_RESP_OKAY);
    rd_chk(a_ovr, 32'h80, 32'hFF, `SPS_RESP_OKAY);
    axi_write(a_ovr, 32'h0, 4'hF, `SPS_RESP_OKAY);
    rd_chk(a_ovr, 32'h0, 32'hFF, `SPS_RESP_OKAY);
    foreach (rows[i]) run_row(rows[i].sel, rows[i].pins, rows[i].exp);
    for (int i = 0; i < 4; i++) begin
      axi_write(a_sel, {24'h0, 6'h00, 2'(i)}, 4'hF, `SPS_RESP_OKAY);
      repeat (2) @(posedge i_clk_sys);
      chk(32'(o_abl_code), 32'(i), "pulse width code");
    end
    axi_write(a_sel, 32'hFF, 4'h0, `SPS_RESP_OKAY);
    rd_chk(a_sel, 32'h3, 32'hFF, `SPS_RESP_OKAY);
    axi_write(12'h400, 32'hFF, 4'hF, `SPS_RESP_SLVERR);
    rd_chk(12'h400, 32'h0, 32'hFFFFFFFF, `SPS_RESP_SLVERR);
    // Default count: four in-window edges do not lock, the fifth does
    run_row(6'h2D, 17'h0, 1'b0);
    i_in_win <= 1'b1;
    pfd_edges(4);
    chk(32'(o_lock_flag), 32'h0, "lock before count");
    pfd_edges(1);
    chk(32'(o_lock_flag), 32'h1, "lock at count");
    chk(32'(o_status_pin), 32'h1, "lock on pin");
    rd_chk(a_liv, 32'h5, 32'h7, `SPS_RESP_OKAY);
    run_row(6'h2A, b_k1 | b_kv, 1'b1);
    run_row(6'h2A, b_k1, 1'b0);
    run_row(6'h3D, 17'h0, 1'b0);
    rd_chk(a_ist, 32'h1, 32'h1, `SPS_RESP_OKAY);
    chk(32'(o_irq), 32'h0, "irq masked");
    axi_write(a_imk, 32'h1, 4'hF, `SPS_RESP_OKAY);
    repeat (3) @(posedge i_clk_sys);
    chk(32'(o_irq), 32'h1, "irq unmasked");
    axi_write(a_ist, 32'h1, 4'hF, `SPS_RESP_OKAY);
    repeat (3) @(posedge i_clk_sys);
    chk(32'(o_irq), 32'h0, "irq cleared");
    // Out-of-window edges must not drop the flag; only the loss input does
    i_in_win <= 1'b0;
    pfd_edges(2);
    chk(32'(o_lock_flag), 32'h1, "lock held");
    i_lock_loss <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
    chk(32'(o_lock_flag), 32'h0, "lock lost");
    rd_chk(a_ist, 32'h2, 32'h2, `SPS_RESP_OKAY);
    i_lock_loss <= 1'b0;
    axi_write(a_lck, 32'hA0, 4'hF, `SPS_RESP_OKAY);
    repeat (2) @(posedge i_clk_sys);
    chk(32'(o_dc_offset_en), 32'h1, "dc offset");
    i_in_win <= 1'b1;
    pfd_edges(15);
    chk(32'(o_lock_flag), 32'h0, "lock before count 16");
    pfd_edges(1);
    chk(32'(o_lock_flag), 32'h1, "lock at count 16");
    // Mid-run reset returns every setting to default
    @(posedge i_clk_sys);
    i_resetn <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    chk(32'({o_dc_offset_en, o_lock_flag, o_abl_code}), 32'h0, "outputs in reset");
    i_resetn <= 1'b1;
    rd_chk(a_lck, 32'h0, 32'hFFFFFFFF, `SPS_RESP_OKAY);
    complete_run();
  end
endmodule : sps_top_test
